// ===== hdl/scfg_pkg.sv
// Package with the map, field layout and decode constants of the stage configuration bank.
package scfg_pkg;

   // Bank geometry: twelve stages of eight word slots, three of them held here.
   localparam int unsigned NSTAGE   = 12;
   localparam int unsigned NSLOT    = 3;
   localparam int unsigned NREG     = NSTAGE * NSLOT;
   localparam int unsigned NROUTE   = 6;
   localparam int unsigned AW       = 12;

   // Register indices (byte address is four times the index).
   localparam logic [9:0] STAGE_BASE_IDX  = 10'h080;
   localparam logic [9:0] BANK_SPAN_IDX   = 10'h060;
   localparam logic [9:0] ROUTE_HIGH_IDX  = 10'h081;
   localparam logic [9:0] OFFSET_TRIM_IDX = 10'h082;
   localparam logic [9:0] THRESH_TUNE_IDX = 10'h083;
   localparam logic [2:0] SLOT_ROUTE      = 3'h1;
   localparam logic [2:0] SLOT_TRIM       = 3'h2;
   localparam logic [2:0] SLOT_TUNE       = 3'h3;

   // Writable-bit masks; unused bits are dropped and read back as zero.
   localparam logic [15:0] ROUTE_MASK = 16'hFFFF;
   localparam logic [15:0] TRIM_MASK  = 16'hBFBF;
   localparam logic [15:0] TUNE_MASK  = 16'h7F7F;
   localparam logic [15:0] CFG_RESET  = 16'h0000;

   // Routing codes for each sensor_input.
   localparam logic [1:0] ROUTE_OFF  = 2'h0;
   localparam logic [1:0] ROUTE_NEG  = 2'h1;
   localparam logic [1:0] ROUTE_POS  = 2'h2;
   localparam logic [1:0] ROUTE_BIAS = 2'h3;
   localparam logic [1:0] MEAS_BAD   = 2'h0;

   // Field positions.
   localparam int unsigned MEAS_LSB      = 12;
   localparam int unsigned MINUS_OFF_BIT = 14;
   localparam int unsigned PLUS_OFF_BIT  = 15;
   localparam int unsigned MINUS_VAL_LSB = 0;
   localparam int unsigned MINUS_STR_BIT = 7;
   localparam int unsigned PLUS_VAL_LSB  = 8;
   localparam int unsigned PLUS_STR_BIT  = 15;
   localparam int unsigned MINUS_THR_LSB = 0;
   localparam int unsigned MINUS_PK_LSB  = 4;
   localparam int unsigned PLUS_THR_LSB  = 8;
   localparam int unsigned PLUS_PK_LSB   = 12;

   // Threshold percentages in hundredths of a percent, listed from code 15 down to code 0.
   localparam logic [15:0][13:0] THR_PCT = {
      14'h253C, 14'h2368, 14'h2194, 14'h1FC0, 14'h1DEA, 14'h1C16, 14'h1A42, 14'h186B,
      14'h1697, 14'h14C3, 14'h12EF, 14'h111B, 14'h0F44, 14'h0D70, 14'h0B9D, 14'h09C4};

   // Peak-detect level: base percent plus a step per code, last defined code.
   localparam logic [6:0] PEAK_BASE = 7'h28;
   localparam logic [6:0] PEAK_STEP = 7'h0A;
   localparam logic [2:0] PEAK_MAX  = 3'h5;

   // Bus handshake phase.
   typedef enum logic [0:0] {
      SCFG_IDLE = 1'b0,
      SCFG_ACK  = 1'b1
   } scfg_phase_e;

endpackage

// ===== hdl/scfg_regs.sv
// APB register bank of per-stage routing, trim and threshold settings with decoded outputs.
//
// Decided for this implementation: the address map and the APB slave port.
module scfg_regs (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [scfg_pkg::AW-1:0]     paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [3:0]                  stage_sel,
   output logic      [scfg_pkg::NROUTE-1:0] route_pos,
   output logic      [scfg_pkg::NROUTE-1:0] route_neg,
   output logic      [scfg_pkg::NROUTE-1:0] route_bias,
   output logic      [1:0]                  measurement_type_select,
   output logic                             measurement_type_bad,
   output logic      [5:0]                  minus_trim_value,
   output logic                             minus_trim_en,
   output logic                             minus_trim_to_pos,
   output logic      [5:0]                  plus_trim_value,
   output logic                             plus_trim_en,
   output logic                             plus_trim_to_neg,
   output logic      [13:0]                 minus_threshold_pct,
   output logic      [13:0]                 plus_threshold_pct,
   output logic      [6:0]                  minus_peak_level,
   output logic      [6:0]                  plus_peak_level,
   output logic                             peak_code_bad
);
   import scfg_pkg::*;

   typedef struct packed {
      scfg_phase_e                 phase;
      logic [NREG-1:0][15:0]       cfg;
      logic [31:0]                 prdata;
      logic                        pready;
      logic                        pslverr;
      logic [NROUTE-1:0]           rpos;
      logic [NROUTE-1:0]           rneg;
      logic [NROUTE-1:0]           rbias;
      logic [1:0]                  meas;
      logic                        meas_bad;
      logic [5:0]                  mval;
      logic                        men;
      logic                        mpos;
      logic [5:0]                  pval;
      logic                        pen;
      logic                        pneg;
      logic [13:0]                 mthr;
      logic [13:0]                 pthr;
      logic [6:0]                  mpk;
      logic [6:0]                  ppk;
      logic                        pk_bad;
   } scfg_state_s;

   scfg_state_s r;
   scfg_state_s r_nxt;

   logic [9:0]        idx_w;
   logic [9:0]        rel_w;
   logic [2:0]        slot_w;
   logic [3:0]        stage_w;
   logic              hit_w;
   logic [5:0]        reg_w;
   logic [15:0]       mask_w;
   logic              wr_fire_w;
   logic              sel_ok_w;
   logic [5:0]        sel_base_w;
   logic [15:0]       sel_route_w;
   logic [15:0]       sel_trim_w;
   logic [15:0]       sel_tune_w;
   logic [NROUTE-1:0] rpos_w;
   logic [NROUTE-1:0] rneg_w;
   logic [NROUTE-1:0] rbias_w;

   // Word decode; the bank holds slots one to three of each eight-word stage group.
   // Only whole aligned words are served; a non-zero paddr[1:0] is refused outright.
   assign idx_w   = paddr[AW-1:2];
   assign rel_w   = idx_w - STAGE_BASE_IDX;
   assign slot_w  = rel_w[2:0];
   assign stage_w = rel_w[6:3];
   assign hit_w   = (idx_w >= STAGE_BASE_IDX) && (rel_w < BANK_SPAN_IDX) &&
                    (slot_w >= SLOT_ROUTE) && (slot_w <= SLOT_TUNE) &&
                    (paddr[1:0] == 2'h0);
   assign reg_w   = 6'(stage_w * 3'h3) + 6'(slot_w - SLOT_ROUTE);
   assign wr_fire_w = (r.phase == SCFG_ACK) && psel && penable && pwrite && hit_w;

   // Unused bits are masked off so a careless write cannot alter them.
   // The routing word has no unused bits, so its mask keeps every bit.
   always_comb begin
      unique case (slot_w)
         SLOT_TRIM: begin
            mask_w = TRIM_MASK;
         end
         SLOT_TUNE: begin
            mask_w = TUNE_MASK;
         end
         default: begin
            mask_w = ROUTE_MASK;
         end
      endcase
   end

   // The converter's current stage picks its three words; an out-of-range stage reads zero.
   // stage_sel comes from the sequencer on this same clock, so it needs no synchroniser.
   assign sel_ok_w    = stage_sel < 4'(NSTAGE);
   assign sel_base_w  = 6'(stage_sel * 3'h3);
   assign sel_route_w = sel_ok_w ? r.cfg[sel_base_w] : CFG_RESET;
   assign sel_trim_w  = sel_ok_w ? r.cfg[sel_base_w + 6'h1] : CFG_RESET;
   assign sel_tune_w  = sel_ok_w ? r.cfg[sel_base_w + 6'h2] : CFG_RESET;

   // Per-input routing decode, one two-bit slice per sensor_input.
   genvar g;
   generate
      for (g = 0; g < NROUTE; g++) begin : g_route
         assign rpos_w[g]  = sel_route_w[2*g +: 2] == ROUTE_POS;
         assign rneg_w[g]  = sel_route_w[2*g +: 2] == ROUTE_NEG;
         assign rbias_w[g] = sel_route_w[2*g +: 2] == ROUTE_BIAS;
      end
   endgenerate

   // Next state: bus handshake, register writes and the decoded stage settings.
   always_comb begin
      r_nxt = r;
      unique case (r.phase)
         SCFG_IDLE: begin
            // No wait state: data and error are prepared during setup, so the
            // access phase always sees a registered answer.
            r_nxt.pready  = 1'b0;
            r_nxt.pslverr = 1'b0;
            if (psel && !penable) begin
               r_nxt.phase   = SCFG_ACK;
               r_nxt.pready  = 1'b1;
               r_nxt.pslverr = !hit_w;
               r_nxt.prdata  = hit_w ? {16'h0000, r.cfg[reg_w]} : 32'h0000_0000;
            end
         end
         SCFG_ACK: begin
            r_nxt.phase   = SCFG_IDLE;
            r_nxt.pready  = 1'b0;
            r_nxt.pslverr = 1'b0;
            if (wr_fire_w) begin
               r_nxt.cfg[reg_w] = pwdata[15:0] & mask_w;
            end
         end
      endcase
      r_nxt.rpos     = rpos_w;
      r_nxt.rneg     = rneg_w;
      r_nxt.rbias    = rbias_w;
      r_nxt.meas     = sel_route_w[MEAS_LSB +: 2];
      r_nxt.meas_bad = sel_route_w[MEAS_LSB +: 2] == MEAS_BAD;
      r_nxt.men      = !sel_route_w[MINUS_OFF_BIT];
      r_nxt.pen      = !sel_route_w[PLUS_OFF_BIT];
      r_nxt.mval     = sel_trim_w[MINUS_VAL_LSB +: 6];
      r_nxt.pval     = sel_trim_w[PLUS_VAL_LSB +: 6];
      r_nxt.mpos     = sel_trim_w[MINUS_STR_BIT];
      r_nxt.pneg     = sel_trim_w[PLUS_STR_BIT];
      r_nxt.mthr     = THR_PCT[sel_tune_w[MINUS_THR_LSB +: 4]];
      r_nxt.pthr     = THR_PCT[sel_tune_w[PLUS_THR_LSB +: 4]];
      r_nxt.mpk      = PEAK_BASE + 7'(sel_tune_w[MINUS_PK_LSB +: 3] * PEAK_STEP);
      r_nxt.ppk      = PEAK_BASE + 7'(sel_tune_w[PLUS_PK_LSB +: 3] * PEAK_STEP);
      // Undefined peak codes are flagged rather than clamped, so the fault stays visible.
      r_nxt.pk_bad   = (sel_tune_w[MINUS_PK_LSB +: 3] > PEAK_MAX) ||
                       (sel_tune_w[PLUS_PK_LSB +: 3] > PEAK_MAX);
   end

   // State register; the device leaves the power-up contents of the words undefined,
   // so zero is chosen here. The decoded outputs then read zero while reset is held,
   // not the decode of zero words; they show that decode from the first edge after it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign prdata                  = r.prdata;
   assign pready                  = r.pready;
   assign pslverr                 = r.pslverr;
   assign route_pos               = r.rpos;
   assign route_neg               = r.rneg;
   assign route_bias              = r.rbias;
   assign measurement_type_select = r.meas;
   assign measurement_type_bad    = r.meas_bad;
   assign minus_trim_value        = r.mval;
   assign minus_trim_en           = r.men;
   assign minus_trim_to_pos       = r.mpos;
   assign plus_trim_value         = r.pval;
   assign plus_trim_en            = r.pen;
   assign plus_trim_to_neg        = r.pneg;
   assign minus_threshold_pct     = r.mthr;
   assign plus_threshold_pct      = r.pthr;
   assign minus_peak_level        = r.mpk;
   assign plus_peak_level         = r.ppk;
   assign peak_code_bad           = r.pk_bad;

   // Checks on the bus answer and on the decoded settings.
   // Reset clears the outputs to zero rather than to the decode of zero words, so the
   // decode checks on outputs where the two differ only start at an edge that has sampled reset released.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_setup_answer: assert property (
      (psel && !penable && r.phase == SCFG_IDLE)
      |=> pready && (pslverr == !$past(hit_w)) ##1 !pready)
      else $error("Setup phase not answered in one cycle.");

   a_write_store: assert property (
      wr_fire_w |=> r.cfg[$past(reg_w)] == ($past(pwdata[15:0]) & $past(mask_w)))
      else $error("Register write not stored with unused bits cleared.");

   a_route_bias: assert property (
      sel_ok_w |=> route_bias[5] == ($past(sel_route_w[11:10]) == ROUTE_BIAS) &&
                   route_neg[0] == ($past(sel_route_w[1:0]) == ROUTE_NEG))
      else $error("Routing decode wrong for an input slice.");

   a_meas_check: assert property (
      presetn |=> measurement_type_bad == ($past(sel_route_w[13:12]) == MEAS_BAD))
      else $error("Measurement type check wrong.");

   a_trim_enable: assert property (
      presetn |=> (minus_trim_en != $past(sel_route_w[14])) &&
               (plus_trim_en != $past(sel_route_w[15])))
      else $error("Trim enable polarity wrong.");

   a_trim_value: assert property (
      1'b1 |=> minus_trim_value == $past(sel_trim_w[5:0]) &&
               plus_trim_value == $past(sel_trim_w[13:8]))
      else $error("Trim magnitude taken from wrong bits.");

   a_trim_steer: assert property (
      1'b1 |=> minus_trim_to_pos == $past(sel_trim_w[7]) &&
               plus_trim_to_neg == $past(sel_trim_w[15]))
      else $error("Trim steering taken from wrong bit.");

   a_thr_ends: assert property (
      (sel_tune_w[3:0] == 4'h0 && sel_tune_w[11:8] == 4'hF)
      |=> minus_threshold_pct == 14'h09C4 && plus_threshold_pct == 14'h253C)
      else $error("Threshold table ends wrong.");

   a_peak_level: assert property (
      (presetn && sel_tune_w[6:4] == 3'h5) |=> minus_peak_level == 7'h5A)
      else $error("Peak level mapping wrong.");

   a_peak_plus: assert property (
      (presetn && sel_tune_w[14:12] == 3'h0 && sel_tune_w[6:4] <= PEAK_MAX)
      |=> plus_peak_level == 7'h28 && !peak_code_bad)
      else $error("Plus peak level or its flag wrong.");

   a_peak_flag: assert property (
      presetn |=> peak_code_bad == (($past(sel_tune_w[6:4]) > PEAK_MAX) ||
                                    ($past(sel_tune_w[14:12]) > PEAK_MAX)))
      else $error("Undefined peak code not flagged.");

   a_thr_minus: assert property (
      (presetn && sel_tune_w[3:0] == 4'h1) |=> minus_threshold_pct == 14'h0B9D)
      else $error("Minus threshold inner code wrong.");

   a_thr_plus: assert property (
      (presetn && sel_tune_w[11:8] == 4'h8) |=> plus_threshold_pct == 14'h186B)
      else $error("Plus threshold inner code wrong.");

   // Bus answer: a refused access returns zero data and leaves every word alone.
   a_miss_data: assert property (
      (psel && !penable && r.phase == SCFG_IDLE && !hit_w) |=> prdata == 32'h0000_0000)
      else $error("Unmapped read returned data.");

   a_read_word: assert property (
      (psel && !penable && r.phase == SCFG_IDLE && hit_w)
      |=> prdata == {16'h0000, $past(r.cfg[reg_w])})
      else $error("Read data not the addressed word.");

   a_miss_keep: assert property (
      (r.phase == SCFG_ACK && psel && penable && pwrite && !hit_w) |=> r.cfg == $past(r.cfg))
      else $error("Unmapped write altered a stored word.");

   a_read_keep: assert property (
      (r.phase == SCFG_ACK && !pwrite) |=> r.cfg == $past(r.cfg))
      else $error("Read access altered a stored word.");

   a_ready_quiet: assert property (
      (r.phase == SCFG_IDLE && !(psel && !penable)) |=> !pready && !pslverr)
      else $error("Ready raised without a setup phase.");

   a_one_wait: assert property (
      (r.phase == SCFG_ACK) |=> r.phase == SCFG_IDLE && !pready)
      else $error("Access phase held longer than one cycle.");

   a_align_refuse: assert property (
      (psel && !penable && r.phase == SCFG_IDLE && paddr[1:0] != 2'h0) |=> pslverr)
      else $error("Misaligned access not refused.");

   a_span_end: assert property (
      (psel && !penable && r.phase == SCFG_IDLE && paddr[AW-1:2] >= 10'h0E0) |=> pslverr)
      else $error("Access beyond the last stage not refused.");

   a_stage_ends: assert property (
      (psel && !penable && r.phase == SCFG_IDLE && (paddr == 12'h204 || paddr == 12'h36C))
      |=> pready && !pslverr)
      else $error("First or last stage word refused.");

   // Decode: slices, exclusivity and the out-of-range stage.
   a_route_pos: assert property (
      presetn |=> route_pos[0] == ($past(sel_route_w[1:0]) == ROUTE_POS) &&
                  route_pos[5] == ($past(sel_route_w[11:10]) == ROUTE_POS))
      else $error("Positive routing taken from wrong slice.");

   a_route_excl: assert property (
      presetn |=> ((route_pos & route_neg) == '0) && ((route_pos & route_bias) == '0) &&
                  ((route_neg & route_bias) == '0))
      else $error("One input routed two ways at once.");

   a_meas_pass: assert property (
      presetn |=> measurement_type_select == $past(sel_route_w[13:12]))
      else $error("Measurement type not passed through.");

   a_sel_range: assert property (
      (presetn && stage_sel >= 4'hC) |=> route_pos == '0 && route_neg == '0 &&
                                         route_bias == '0 && minus_threshold_pct == 14'h09C4)
      else $error("Stage beyond the bank not decoded as zero words.");

endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the stage configuration bank over its APB port.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import scfg_pkg::*;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  stage_sel;
   logic [5:0]  route_pos, route_neg, route_bias, minus_trim_value, plus_trim_value;
   logic [1:0]  measurement_type_select;
   logic        measurement_type_bad, minus_trim_en, minus_trim_to_pos;
   logic        plus_trim_en, plus_trim_to_neg, peak_code_bad;
   logic [13:0] minus_threshold_pct, plus_threshold_pct;
   logic [6:0]  minus_peak_level, plus_peak_level;
   logic [15:0] rw_a [12];
   logic [15:0] tw_a [12];
   logic [15:0] sw_a [12];
   int          fails, n_checks;

   // Threshold percentages in hundredths, kept separately from the design's table.
   localparam logic [13:0] THR_T [16] = '{14'h09C4, 14'h0B9D, 14'h0D70, 14'h0F44,
      14'h111B, 14'h12EF, 14'h14C3, 14'h1697, 14'h186B, 14'h1A42, 14'h1C16, 14'h1DEA,
      14'h1FC0, 14'h2194, 14'h2368, 14'h253C};

   scfg_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stage_sel(stage_sel), .route_pos(route_pos),
      .route_neg(route_neg), .route_bias(route_bias),
      .measurement_type_select(measurement_type_select),
      .measurement_type_bad(measurement_type_bad), .minus_trim_value(minus_trim_value),
      .minus_trim_en(minus_trim_en), .minus_trim_to_pos(minus_trim_to_pos),
      .plus_trim_value(plus_trim_value), .plus_trim_en(plus_trim_en),
      .plus_trim_to_neg(plus_trim_to_neg), .minus_threshold_pct(minus_threshold_pct),
      .plus_threshold_pct(plus_threshold_pct), .minus_peak_level(minus_peak_level),
      .plus_peak_level(plus_peak_level), .peak_code_bad(peak_code_bad));

   // Free-running 250 MHz clock.
   always #2 pclk = ~pclk;

   task automatic print_verdict();
      if (fails == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      // Ready is looked at on the falling edge before each rising edge, so the
      // sample is never raced by the register that launches or clears it.
      n = 0;
      @(negedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(negedge pclk);
         n++;
      end
      if (pready !== 1'b1) begin
         fails++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr_chk(input logic [11:0] a, input logic [15:0] d, input logic e);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
      chk(32'(err), 32'(e));
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [15:0] d, input logic e);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 16'h0000, rd, err);
      chk(32'(err), 32'(e));
      chk(rd, {16'h0000, d});
   endtask

   // Byte address of slot k (0 routing, 1 trim, 2 tuning) of stage s.
   function automatic logic [11:0] adr(input int s, input int k);
      return 12'((12'h081 + 8 * s + k) * 4);
   endfunction

   // Selects a stage and compares every decoded output with the field values.
   task automatic check_dec(input int s, input logic [15:0] rw, tw, sw);
      logic [5:0] ep, en, eb;
      for (int g = 0; g < 6; g++) begin
         ep[g] = (rw[2*g+:2] == 2'h2);
         en[g] = (rw[2*g+:2] == 2'h1);
         eb[g] = (rw[2*g+:2] == 2'h3);
      end
      stage_sel <= 4'(s);
      // One edge of latency; the settled outputs are read on the falling edge after it.
      @(posedge pclk);
      @(negedge pclk);
      chk(32'(route_pos), 32'(ep));
      chk(32'(route_neg), 32'(en));
      chk(32'(route_bias), 32'(eb));
      chk(32'({measurement_type_select, measurement_type_bad}),
          32'({rw[13:12], rw[13:12] == 2'h0}));
      chk(32'({minus_trim_en, plus_trim_en}), 32'({~rw[14], ~rw[15]}));
      chk(32'({minus_trim_to_pos, minus_trim_value}), 32'({tw[7], tw[5:0]}));
      chk(32'({plus_trim_to_neg, plus_trim_value}), 32'({tw[15], tw[13:8]}));
      chk(32'(minus_threshold_pct), 32'(THR_T[sw[3:0]]));
      chk(32'(plus_threshold_pct), 32'(THR_T[sw[11:8]]));
      chk(32'(minus_peak_level), 32'(7'h28 + 7'h0A * sw[6:4]));
      chk(32'(plus_peak_level), 32'(7'h28 + 7'h0A * sw[14:12]));
      chk(32'(peak_code_bad), 32'(sw[6:4] > 3'h5 || sw[14:12] > 3'h5));
      @(posedge pclk);
   endtask

   // Main sequence; software values keep unused bits zero and avoid type code 00.
   initial begin
      int k;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      stage_sel = '0;
      fails = 0;
      n_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check_dec(0, 16'h0000, 16'h0000, 16'h0000);
      // Sixteen passes cover every threshold code; the last four reuse stages 0 to 3.
      for (int s = 0; s < 16; s++) begin
         k = s % 12;
         rw_a[k] = ((16'h09E4 + 16'(s) * 16'h0123) & 16'h0FFF) | (16'(s % 3 + 1) << 12)
                   | (16'(s & 3) << 14);
         tw_a[k] = ((16'(s) * 16'h0705) & 16'h3F3F) | (16'(s & 1) << 7) | (16'(s & 2) << 14);
         sw_a[k] = 16'(s) | (16'(15 - s) << 8) | (16'(s % 6) << 4)
                   | (16'((s + 3) % 6) << 12);
         wr_chk(adr(k, 0), rw_a[k], 1'b0);
         wr_chk(adr(k, 1), tw_a[k], 1'b0);
         wr_chk(adr(k, 2), sw_a[k], 1'b0);
         check_dec(k, rw_a[k], tw_a[k], sw_a[k]);
      end
      // Read everything back so that any aliasing between stages shows.
      for (int s = 0; s < 12; s++) begin
         rd_chk(adr(s, 0), rw_a[s], 1'b0);
         rd_chk(adr(s, 1), tw_a[s], 1'b0);
         rd_chk(adr(s, 2), sw_a[s], 1'b0);
      end
      check_dec(12, 16'h0000, 16'h0000, 16'h0000);
      check_dec(15, 16'h0000, 16'h0000, 16'h0000);
      rd_chk(12'h200, 16'h0000, 1'b1);
      rd_chk(12'h210, 16'h0000, 1'b1);
      rd_chk(12'h380, 16'h0000, 1'b1);
      rd_chk(12'h205, 16'h0000, 1'b1);
      wr_chk(12'h205, 16'h0000, 1'b1);
      wr_chk(12'h210, 16'h1234, 1'b1);
      rd_chk(12'h204, rw_a[0], 1'b0);
      // Ones in unused bits are dropped; peak code 7 raises the bad flag.
      wr_chk(12'h208, 16'hFFFF, 1'b0);
      wr_chk(12'h20C, 16'hFFFF, 1'b0);
      rd_chk(12'h208, 16'hBFBF, 1'b0);
      rd_chk(12'h20C, 16'h7F7F, 1'b0);
      check_dec(0, rw_a[0], 16'hBFBF, 16'h7F7F);
      print_verdict();
   end
endmodule
